/* verilog/interrupt_request_flags_pkg.sv */
// Constants, register map and timing of the interrupt request flag block.
package interrupt_request_flags_pkg;

  localparam int CLOCK_MHZ = 100;
  localparam int SE0_MIN_NS = 2500;
  localparam int SE0_CYCLES = (SE0_MIN_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [8:0] SE0_COUNT_LAST = 9'(SE0_CYCLES - 1);
  localparam logic [8:0] SE0_COUNT_FULL = 9'(SE0_CYCLES);

  // Register indices; the bus byte address is four times the index.
  localparam logic [7:0] TIMER_EXT_CONTROL_INDEX = 8'h88;
  localparam logic [7:0] EDGE_POLARITY_INDEX = 8'h9a;
  localparam logic [7:0] SERIAL_ENABLE_INDEX = 8'ha9;
  localparam logic [7:0] SERIAL_FLAGS_INDEX = 8'hab;
  localparam logic [7:0] USB_EVENTS_INDEX = 8'hc4;
  localparam logic [7:0] ENDPOINT_REQUESTS_INDEX = 8'hd6;
  localparam logic [7:0] ENDPOINT_SELECT_DEVICE = 8'h80;

  localparam int TIMER1_FLAG_BIT = 7;
  localparam int TIMER1_RUN_BIT = 6;
  localparam int TIMER0_FLAG_BIT = 5;
  localparam int TIMER0_RUN_BIT = 4;
  localparam int EXT1_FLAG_BIT = 3;
  localparam int EXT1_TRIGGER_BIT = 2;
  localparam int EXT0_FLAG_BIT = 1;
  localparam int EXT0_TRIGGER_BIT = 0;

  localparam int EXT0_RISING_BIT = 0;
  localparam int EXT0_FALLING_BIT = 1;
  localparam int EXT1_RISING_BIT = 2;
  localparam int EXT1_FALLING_BIT = 3;

  localparam int TRANSFER_COMPLETE_BIT = 0;
  localparam int WRITE_COLLISION_BIT = 1;
  localparam int COMPLETE_ENABLE_BIT = 0;
  localparam int COLLISION_ENABLE_BIT = 1;

  localparam int SINGLE_ENDED_ZERO_BIT = 7;
  localparam int ATTACH_BIT = 6;
  localparam int DETACH_BIT = 5;
  localparam int SUSPEND_BEGIN_BIT = 4;
  localparam int SUSPEND_END_BIT = 3;
  localparam int STATUS_NACK_BIT = 2;
  localparam int SETUP_RECEIVED_BIT = 1;
  localparam int FRAME_START_BIT = 0;

  localparam int REQUEST_VALUE_BIT = 7;
  localparam int ENDPOINT_COUNT = 5;

  localparam logic [7:0] TIMER_EXT_CONTROL_RESET = 8'h00;
  localparam logic [3:0] EDGE_POLARITY_RESET = 4'ha;
  localparam logic [1:0] SERIAL_FLAGS_RESET = 2'h0;
  localparam logic [1:0] SERIAL_ENABLE_RESET = 2'h0;
  localparam logic [7:0] USB_EVENTS_RESET = 8'h00;
  localparam logic [7:0] ENDPOINT_REQUESTS_RESET = 8'h00;

endpackage : interrupt_request_flags_pkg

/* verilog/pin_edge_sync.sv */
// Two-stage pin synchroniser with edge detection on the synchronised level.
`timescale 1ns/1ps
module pin_edge_sync #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic pinAsync,
  output logic level,
  output logic rise,
  output logic fall
);

  logic stage1_reg;
  logic stage2_reg;
  logic prev_reg;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1_reg <= IDLE_LEVEL;
      stage2_reg <= IDLE_LEVEL;
      prev_reg <= IDLE_LEVEL;
    end else begin
      stage1_reg <= pinAsync;
      stage2_reg <= stage1_reg;
      prev_reg <= stage2_reg;
    end
  end

  assign level = stage2_reg;
  assign rise = stage2_reg & ~prev_reg;
  assign fall = ~stage2_reg & prev_reg;

endmodule : pin_edge_sync

/* verilog/interrupt_request_flags.sv */
// Interrupt request flags for timers, external pins, serial channel and USB device events.
//
// Notes on behaviour
// - Timer overflow sets flag; vectoring clears it.
// - Edge mode: selected pin edge sets flag.
// - Trigger select 0 is level, 1 edge.
// - Rising, falling or both edges selectable.
// - Level mode flag follows pin; no vector clear.
// - Transmit write during transfer sets collision flag.
// - Collision requests only with its enable set.
// - Transfer end sets complete flag; enable gates it.
// - Serial request is OR of both flags, each gated by its enable.
// - Writing 0 clears a serial flag.
// - Flags read then transmit write clears collision.
// - Flags read then receive read clears complete.
// - Reading device event register clears set flags.
// - Single-ended zero held 2.5 us sets flag.
// - Attach and detach each set own flag.
// - Suspend entry and exit each set flag.
// - Status request answered NACK sets flag.
// - Good setup packet sets setup flag.
// - Frame start packet sets bit 0 flag.
// - Configuration or interface request sets value flag.
// - Value flag clears only by writing 0.
// - Endpoint pending flags clear on register read.
`timescale 1ns/1ps
module interrupt_request_flags
  import interrupt_request_flags_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer0Overflow,
  input wire logic timer1Overflow,
  input wire logic vectorTimer0,
  input wire logic vectorTimer1,
  input wire logic vectorExt0,
  input wire logic vectorExt1,
  input wire logic ext0Pin,
  input wire logic ext1Pin,
  input wire logic serialBusy,
  input wire logic serialTxWrite,
  input wire logic serialRxRead,
  input wire logic serialDone,
  input wire logic [7:0] endpointSelect,
  input wire logic se0Line,
  input wire logic attachDetected,
  input wire logic detachDetected,
  input wire logic suspendEntered,
  input wire logic suspendLeft,
  input wire logic statusNacked,
  input wire logic setupReceived,
  input wire logic frameStartSeen,
  input wire logic requestValueSeen,
  input wire logic [4:0] endpointEvent,
  output logic [1:0] timerRun,
  output logic timer0Request,
  output logic timer1Request,
  output logic ext0Request,
  output logic ext1Request,
  output logic serialRequest,
  output logic [7:0] deviceEvents,
  output logic [7:0] endpointRequests
);

  logic ackReg;
  logic [7:0] datReg;
  logic [7:0] tconReg;
  logic [7:0] tconNext;
  logic [3:0] edgeSelReg;
  logic [1:0] serialEnableReg;
  logic [1:0] serialFlagsReg;
  logic [1:0] serialFlagsNext;
  logic wcolArmedReg;
  logic tcArmedReg;
  logic serialRequestReg;
  logic [7:0] dirrReg;
  logic [7:0] dirrNext;
  logic [7:0] dirrSet;
  logic [7:0] gepirReg;
  logic [7:0] gepirNext;
  logic [8:0] se0CountReg;
  logic [8:0] se0CountNext;

  logic [7:0] regIndex;
  logic [7:0] wd;
  logic reqNew;
  logic reqDone;
  logic wrByte;
  logic rdDone;
  logic hitTcon;
  logic hitEdge;
  logic hitScien;
  logic hitScf;
  logic hitDirr;
  logic hitGepir;
  logic wrTcon;
  logic wrScf;
  logic rdScf;
  logic rdDirr;
  logic rdGepir;
  logic [7:0] readValue;
  logic ext0Level;
  logic ext0Rise;
  logic ext0Fall;
  logic ext1Level;
  logic ext1Rise;
  logic ext1Fall;
  logic ext0Edge;
  logic ext1Edge;
  logic se0Level;
  logic se0Set;
  logic collisionSet;
  logic wcolClearHw;
  logic tcClearHw;

  pin_edge_sync #(.IDLE_LEVEL(1'b1)) ext0Sync (
    .clock(clock), .reset_n(reset_n), .pinAsync(ext0Pin),
    .level(ext0Level), .rise(ext0Rise), .fall(ext0Fall)
  );

  pin_edge_sync #(.IDLE_LEVEL(1'b1)) ext1Sync (
    .clock(clock), .reset_n(reset_n), .pinAsync(ext1Pin),
    .level(ext1Level), .rise(ext1Rise), .fall(ext1Fall)
  );

  pin_edge_sync #(.IDLE_LEVEL(1'b0)) se0Sync (
    .clock(clock), .reset_n(reset_n), .pinAsync(se0Line),
    .level(se0Level), .rise(), .fall()
  );

  // Bus decode; the answer comes one cycle after the request and side effects act at the ack edge.
  assign regIndex = wb_adr_i[9:2];
  assign wd = wb_dat_i[7:0];
  assign reqNew = wb_cyc_i & wb_stb_i & ~ackReg;
  assign reqDone = wb_cyc_i & wb_stb_i & ackReg;
  assign wrByte = reqDone & wb_we_i & wb_sel_i[0];
  assign rdDone = reqDone & ~wb_we_i;
  assign hitTcon = regIndex == TIMER_EXT_CONTROL_INDEX;
  assign hitEdge = regIndex == EDGE_POLARITY_INDEX;
  assign hitScien = regIndex == SERIAL_ENABLE_INDEX;
  assign hitScf = regIndex == SERIAL_FLAGS_INDEX;
  assign hitDirr = (regIndex == USB_EVENTS_INDEX) & (endpointSelect == ENDPOINT_SELECT_DEVICE);
  assign hitGepir = regIndex == ENDPOINT_REQUESTS_INDEX;
  assign wrTcon = wrByte & hitTcon;
  assign wrScf = wrByte & hitScf;
  assign rdScf = rdDone & hitScf;
  assign rdDirr = rdDone & hitDirr;
  assign rdGepir = rdDone & hitGepir;

  assign readValue = hitTcon ? tconReg :
                     hitEdge ? {4'h0, edgeSelReg} :
                     hitScien ? {6'h00, serialEnableReg} :
                     hitScf ? {6'h00, serialFlagsReg} :
                     hitDirr ? dirrReg :
                     hitGepir ? gepirReg : 8'h00;

  // Timer flags: a write of the register wins over vectoring, an overflow wins over both.
  assign tconNext[TIMER1_FLAG_BIT] = timer1Overflow |
    (wrTcon ? wd[TIMER1_FLAG_BIT] : tconReg[TIMER1_FLAG_BIT] & ~vectorTimer1);
  assign tconNext[TIMER0_FLAG_BIT] = timer0Overflow |
    (wrTcon ? wd[TIMER0_FLAG_BIT] : tconReg[TIMER0_FLAG_BIT] & ~vectorTimer0);
  assign tconNext[TIMER1_RUN_BIT] = wrTcon ? wd[TIMER1_RUN_BIT] : tconReg[TIMER1_RUN_BIT];
  assign tconNext[TIMER0_RUN_BIT] = wrTcon ? wd[TIMER0_RUN_BIT] : tconReg[TIMER0_RUN_BIT];
  assign tconNext[EXT1_TRIGGER_BIT] = wrTcon ? wd[EXT1_TRIGGER_BIT] : tconReg[EXT1_TRIGGER_BIT];
  assign tconNext[EXT0_TRIGGER_BIT] = wrTcon ? wd[EXT0_TRIGGER_BIT] : tconReg[EXT0_TRIGGER_BIT];

  assign ext0Edge = (ext0Rise & edgeSelReg[EXT0_RISING_BIT]) |
                    (ext0Fall & edgeSelReg[EXT0_FALLING_BIT]);
  assign ext1Edge = (ext1Rise & edgeSelReg[EXT1_RISING_BIT]) |
                    (ext1Fall & edgeSelReg[EXT1_FALLING_BIT]);

  // Level mode tracks a low pin; edge mode latches the edge until vectoring.
  assign tconNext[EXT0_FLAG_BIT] = !tconReg[EXT0_TRIGGER_BIT] ? ~ext0Level :
    (ext0Edge | (wrTcon ? wd[EXT0_FLAG_BIT] : tconReg[EXT0_FLAG_BIT] & ~vectorExt0));
  assign tconNext[EXT1_FLAG_BIT] = !tconReg[EXT1_TRIGGER_BIT] ? ~ext1Level :
    (ext1Edge | (wrTcon ? wd[EXT1_FLAG_BIT] : tconReg[EXT1_FLAG_BIT] & ~vectorExt1));

  // Serial channel flags.
  assign collisionSet = serialTxWrite & serialBusy;
  assign wcolClearHw = wcolArmedReg & serialTxWrite;
  assign tcClearHw = tcArmedReg & serialRxRead;
  assign serialFlagsNext[WRITE_COLLISION_BIT] = collisionSet |
    (serialFlagsReg[WRITE_COLLISION_BIT] & ~wcolClearHw &
     ~(wrScf & ~wd[WRITE_COLLISION_BIT]));
  assign serialFlagsNext[TRANSFER_COMPLETE_BIT] = serialDone |
    (serialFlagsReg[TRANSFER_COMPLETE_BIT] & ~tcClearHw &
     ~(wrScf & ~wd[TRANSFER_COMPLETE_BIT]));

  // USB device events.
  assign se0Set = se0Level & (se0CountReg == SE0_COUNT_LAST);
  assign se0CountNext = !se0Level ? 9'h000 :
                        (se0CountReg == SE0_COUNT_FULL) ? se0CountReg : se0CountReg + 9'h001;
  assign dirrSet[SINGLE_ENDED_ZERO_BIT] = se0Set;
  assign dirrSet[ATTACH_BIT] = attachDetected;
  assign dirrSet[DETACH_BIT] = detachDetected;
  assign dirrSet[SUSPEND_BEGIN_BIT] = suspendEntered;
  assign dirrSet[SUSPEND_END_BIT] = suspendLeft;
  assign dirrSet[STATUS_NACK_BIT] = statusNacked;
  assign dirrSet[SETUP_RECEIVED_BIT] = setupReceived;
  assign dirrSet[FRAME_START_BIT] = frameStartSeen;
  // Only the bits that were handed out on the bus are cleared by the read.
  assign dirrNext = dirrSet | (dirrReg & ~(rdDirr ? datReg : 8'h00));

  assign gepirNext[REQUEST_VALUE_BIT] = requestValueSeen |
    (gepirReg[REQUEST_VALUE_BIT] & ~(wrByte & hitGepir & ~wd[REQUEST_VALUE_BIT]));
  assign gepirNext[REQUEST_VALUE_BIT-1:ENDPOINT_COUNT] = 2'h0;
  assign gepirNext[ENDPOINT_COUNT-1:0] = endpointEvent |
    (gepirReg[ENDPOINT_COUNT-1:0] & ~(rdGepir ? datReg[ENDPOINT_COUNT-1:0] : 5'h00));

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ackReg <= 1'b0;
      datReg <= 8'h00;
    end else begin
      ackReg <= reqNew;
      if (reqNew) begin
        datReg <= readValue;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tconReg <= TIMER_EXT_CONTROL_RESET;
      edgeSelReg <= EDGE_POLARITY_RESET;
      serialEnableReg <= SERIAL_ENABLE_RESET;
    end else begin
      tconReg <= tconNext;
      if (wrByte & hitEdge) begin
        edgeSelReg <= wd[3:0];
      end
      if (wrByte & hitScien) begin
        serialEnableReg <= wd[1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      serialFlagsReg <= SERIAL_FLAGS_RESET;
      wcolArmedReg <= 1'b0;
      tcArmedReg <= 1'b0;
      serialRequestReg <= 1'b0;
    end else begin
      serialFlagsReg <= serialFlagsNext;
      wcolArmedReg <= rdScf | (wcolArmedReg & ~serialTxWrite);
      tcArmedReg <= rdScf | (tcArmedReg & ~serialRxRead);
      serialRequestReg <=
        (serialFlagsReg[WRITE_COLLISION_BIT] & serialEnableReg[COLLISION_ENABLE_BIT]) |
        (serialFlagsReg[TRANSFER_COMPLETE_BIT] & serialEnableReg[COMPLETE_ENABLE_BIT]);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dirrReg <= USB_EVENTS_RESET;
      gepirReg <= ENDPOINT_REQUESTS_RESET;
      se0CountReg <= 9'h000;
    end else begin
      dirrReg <= dirrNext;
      gepirReg <= gepirNext;
      se0CountReg <= se0CountNext;
    end
  end

  assign wb_dat_o = {24'h00_0000, datReg};
  assign wb_ack_o = ackReg;
  assign timerRun = {tconReg[TIMER1_RUN_BIT], tconReg[TIMER0_RUN_BIT]};
  assign timer0Request = tconReg[TIMER0_FLAG_BIT];
  assign timer1Request = tconReg[TIMER1_FLAG_BIT];
  assign ext0Request = tconReg[EXT0_FLAG_BIT];
  assign ext1Request = tconReg[EXT1_FLAG_BIT];
  assign serialRequest = serialRequestReg;
  assign deviceEvents = dirrReg;
  assign endpointRequests = gepirReg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_bus_request;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_single_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_bus_answer;
    s_bus_request |=> s_single_ack;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus ack not a single cycle pulse");

  property p_timer0_set;
    timer0Overflow |=> timer0Request;
  endproperty
  a_timer0_set: assert property (p_timer0_set) else $error("timer 0 flag not set");

  property p_timer1_vector_clear;
    timer1Request && vectorTimer1 && !timer1Overflow && !wrTcon |=> !timer1Request;
  endproperty
  a_timer1_vector_clear: assert property (p_timer1_vector_clear)
    else $error("timer 1 flag not cleared on vector");

  property p_ext0_level_follow;
    !tconReg[EXT0_TRIGGER_BIT] && !wrTcon |=> ext0Request == !$past(ext0Level);
  endproperty
  a_ext0_level_follow: assert property (p_ext0_level_follow)
    else $error("level mode flag does not follow pin");

  property p_ext1_edge_set;
    tconReg[EXT1_TRIGGER_BIT] && ext1Fall && edgeSelReg[EXT1_FALLING_BIT] |=> ext1Request;
  endproperty
  a_ext1_edge_set: assert property (p_ext1_edge_set) else $error("edge not latched");

  property p_ext0_unselected_edge;
    tconReg[EXT0_TRIGGER_BIT] && !ext0Request && !wrTcon && ext0Rise &&
      !edgeSelReg[EXT0_RISING_BIT] |=> !ext0Request;
  endproperty
  a_ext0_unselected_edge: assert property (p_ext0_unselected_edge)
    else $error("unselected edge raised a request");

  property p_collision_set;
    serialTxWrite && serialBusy |=> serialFlagsReg[WRITE_COLLISION_BIT];
  endproperty
  a_collision_set: assert property (p_collision_set) else $error("collision flag missed");

  property p_serial_request;
    ##1 serialRequest == $past(
      (serialFlagsReg[WRITE_COLLISION_BIT] & serialEnableReg[COLLISION_ENABLE_BIT]) |
      (serialFlagsReg[TRANSFER_COMPLETE_BIT] & serialEnableReg[COMPLETE_ENABLE_BIT]));
  endproperty
  a_serial_request: assert property (p_serial_request)
    else $error("serial request is not the gated OR of its flags");

  property p_complete_auto_clear;
    rdScf && !serialDone ##1 !serialDone && !serialRxRead ##1 serialRxRead && !serialDone
      |=> !serialFlagsReg[TRANSFER_COMPLETE_BIT];
  endproperty
  a_complete_auto_clear: assert property (p_complete_auto_clear)
    else $error("complete flag not cleared after read sequence");

  property p_device_read_clear;
    rdDirr && dirrReg == datReg && !se0Set && !attachDetected && !detachDetected &&
      !suspendEntered && !suspendLeft && !statusNacked && !setupReceived && !frameStartSeen
      |=> dirrReg == 8'h00;
  endproperty
  a_device_read_clear: assert property (p_device_read_clear)
    else $error("device events survived a read");

  property p_se0_time;
    se0Level && se0CountReg == SE0_COUNT_LAST |=> dirrReg[SINGLE_ENDED_ZERO_BIT];
  endproperty
  a_se0_time: assert property (p_se0_time) else $error("single ended zero flag missed");

  property p_request_value_hold;
    gepirReg[REQUEST_VALUE_BIT] && !(wrByte && hitGepir && !wd[REQUEST_VALUE_BIT])
      |=> gepirReg[REQUEST_VALUE_BIT];
  endproperty
  a_request_value_hold: assert property (p_request_value_hold)
    else $error("request value flag lost without a zero write");

endmodule : interrupt_request_flags

/* verification/cpu_core_model.sv */
// CPU core model that vectors to service routines and selects the register page.
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic clock,
  output logic [3:0] vectorPulse,
  output logic [7:0] endpointSelect
);
  initial begin
    vectorPulse = 4'h0;
    endpointSelect = 8'h00;
  end

  // Vector order is timer0, timer1, ext0, ext1; each vector lasts one cycle.
  task automatic vectorTo(input int which);
    @(posedge clock);
    vectorPulse[which] <= 1'b1;
    @(posedge clock);
    vectorPulse <= 4'h0;
    #1;
  endtask : vectorTo

  task automatic selectPage(input logic [7:0] page);
    @(posedge clock);
    endpointSelect <= page;
  endtask : selectPage
endmodule : cpu_core_model

/* verification/interrupt_request_flags_bench.sv */
// Self-checking bench for the interrupt request flag block.
`timescale 1ns/1ps
module interrupt_request_flags_bench
  import interrupt_request_flags_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [31:0] wbAdr = 32'h0000_0000;
  logic [31:0] wbDatW = 32'h0000_0000;
  logic [3:0] wbSel = 4'hf;
  logic [31:0] rdTmp;
  logic [31:0] wbDatR;
  logic wbAck;
  logic [17:0] evt = 18'h0_0000;
  logic [1:0] pins = 2'h3;
  logic busy = 1'b0;
  logic se0 = 1'b0;
  logic [3:0] vec;
  logic [3:0] req;
  logic [7:0] endpoint_select;
  logic [1:0] timerRun;
  logic serialRequest;
  logic [7:0] deviceEvents;
  logic [7:0] endpointRequests;
  int failCount = 0;
  int compares = 0;
  logic [7:0] resetIdx [6] = '{TIMER_EXT_CONTROL_INDEX, EDGE_POLARITY_INDEX,
    SERIAL_ENABLE_INDEX, SERIAL_FLAGS_INDEX, USB_EVENTS_INDEX, ENDPOINT_REQUESTS_INDEX};
  logic [7:0] resetVal [6] = '{TIMER_EXT_CONTROL_RESET, {4'h0, EDGE_POLARITY_RESET},
    {6'h00, SERIAL_ENABLE_RESET}, {6'h00, SERIAL_FLAGS_RESET}, USB_EVENTS_RESET,
    ENDPOINT_REQUESTS_RESET};

  always #5 clock = ~clock;

  cpu_core_model cpu (.clock(clock), .vectorPulse(vec), .endpointSelect(endpoint_select));

  interrupt_request_flags DUT (
    .clock(clock), .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .timer0Overflow(evt[8]),
    .timer1Overflow(evt[9]), .vectorTimer0(vec[0]), .vectorTimer1(vec[1]),
    .vectorExt0(vec[2]), .vectorExt1(vec[3]), .ext0Pin(pins[0]), .ext1Pin(pins[1]),
    .serialBusy(busy), .serialTxWrite(evt[10]), .serialRxRead(evt[11]),
    .serialDone(evt[12]), .endpointSelect(endpoint_select), .se0Line(se0),
    .attachDetected(evt[6]), .detachDetected(evt[5]), .suspendEntered(evt[4]),
    .suspendLeft(evt[3]), .statusNacked(evt[2]), .setupReceived(evt[1]),
    .frameStartSeen(evt[0]), .requestValueSeen(evt[7]), .endpointEvent(evt[17:13]),
    .timerRun(timerRun), .timer0Request(req[0]), .timer1Request(req[1]),
    .ext0Request(req[2]), .ext1Request(req[3]), .serialRequest(serialRequest),
    .deviceEvents(deviceEvents), .endpointRequests(endpointRequests)
  );

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One classic cycle; the request is held until ack is sampled high.
  task automatic wbXfer(input logic we, input logic [7:0] idx, input logic [7:0] wdata,
                        input logic [3:0] sel, output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= sel;
    wbAdr <= {22'h00_0000, idx, 2'b00};
    wbDatW <= {24'h00_0000, wdata};
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rdata = wbDatR;
    if (n >= 50) begin
      failCount++;
      conclude();
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wbXfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    wbXfer(1'b1, idx, d, 4'hf, rd);
  endtask : wr

  task automatic rdChk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    wbXfer(1'b0, idx, 8'h00, 4'hf, rd);
    check(what, rd, {24'h00_0000, exp});
  endtask : rdChk

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic pulse(input logic [17:0] m);
    @(posedge clock);
    evt <= m;
    @(posedge clock);
    evt <= 18'h0_0000;
    #1;
  endtask : pulse

  task automatic setPins(input logic [1:0] v);
    @(posedge clock);
    pins <= v;
    tick(6);
  endtask : setPins

  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    cpu.selectPage(ENDPOINT_SELECT_DEVICE);
    for (int i = 0; i < 6; i++) begin
      rdChk("reset value", resetIdx[i], resetVal[i]);
    end
    for (int t = 0; t < 2; t++) begin
      pulse(18'h0_0100 << t);
      check("timer flag", req[t], 1'b1);
      rdChk("control", TIMER_EXT_CONTROL_INDEX, t ? 8'h80 : 8'h20);
      fork
        pulse(18'h0_0100 << t);
        cpu.vectorTo(t);
      join
      check("timer set wins", req[t], 1'b1);
      cpu.vectorTo(t);
      check("timer vector clear", req[t], 1'b0);
    end
    setPins(2'h0);
    check("level request", req[3:2], 2'h3);
    cpu.vectorTo(2);
    check("level no clear", req[3:2], 2'h3);
    setPins(2'h3);
    check("level follows pin", req[3:2], 2'h0);
    wr(TIMER_EXT_CONTROL_INDEX, 8'h55);
    tick(0);
    check("run bits", timerRun, 2'h3);
    rdChk("control", TIMER_EXT_CONTROL_INDEX, 8'h55);
    for (int s = 1; s < 4; s++) begin
      wr(EDGE_POLARITY_INDEX, 8'(s | (s << 2)));
      setPins(2'h0);
      check("falling edge", req[3:2], {2{s[1]}});
      cpu.vectorTo(2);
      cpu.vectorTo(3);
      check("edge vector clear", req[3:2], 2'h0);
      setPins(2'h3);
      check("rising edge", req[3:2], {2{s[0]}});
      cpu.vectorTo(2);
      cpu.vectorTo(3);
    end
    @(posedge clock);
    busy <= 1'b1;
    pulse(18'h0_0400);
    tick(1);
    check("masked collision", serialRequest, 1'b0);
    rdChk("collision", SERIAL_FLAGS_INDEX, 8'h02);
    wr(SERIAL_ENABLE_INDEX, 8'h02);
    tick(2);
    check("collision request", serialRequest, 1'b1);
    @(posedge clock);
    busy <= 1'b0;
    pulse(18'h0_1000);
    rdChk("both flags", SERIAL_FLAGS_INDEX, 8'h03);
    pulse(18'h0_0400);
    rdChk("collision auto clear", SERIAL_FLAGS_INDEX, 8'h01);
    pulse(18'h0_0800);
    rdChk("complete auto clear", SERIAL_FLAGS_INDEX, 8'h00);
    wr(SERIAL_ENABLE_INDEX, 8'h01);
    pulse(18'h0_1000);
    tick(1);
    check("complete request", serialRequest, 1'b1);
    @(posedge clock);
    busy <= 1'b1;
    pulse(18'h0_0400);
    wr(SERIAL_FLAGS_INDEX, 8'h01);
    rdChk("write zero clears", SERIAL_FLAGS_INDEX, 8'h01);
    wr(SERIAL_FLAGS_INDEX, 8'h00);
    rdChk("write zero clears", SERIAL_FLAGS_INDEX, 8'h00);
    tick(2);
    check("serial idle", serialRequest, 1'b0);
    cpu.selectPage(8'h00);
    // Each device event except single-ended zero gets its own pulse; only the combined value 7f is checked afterwards.
    for (int b = 0; b < 7; b++) begin
      pulse(18'h0_0001 << b);
    end
    check("device events", deviceEvents, 8'h7f);
    rdChk("wrong page", USB_EVENTS_INDEX, 8'h00);
    cpu.selectPage(ENDPOINT_SELECT_DEVICE);
    rdChk("device events", USB_EVENTS_INDEX, 8'h7f);
    rdChk("read clears", USB_EVENTS_INDEX, 8'h00);
    @(posedge clock);
    se0 <= 1'b1;
    tick(20);
    @(posedge clock);
    se0 <= 1'b0;
    tick(5);
    check("short zero", deviceEvents[7], 1'b0);
    @(posedge clock);
    se0 <= 1'b1;
    tick(SE0_CYCLES - 8);
    check("zero too short", deviceEvents[7], 1'b0);
    tick(16);
    check("zero flag", deviceEvents[7], 1'b1);
    @(posedge clock);
    se0 <= 1'b0;
    rdChk("zero read", USB_EVENTS_INDEX, 8'h80);
    pulse(18'h0_0080);
    for (int b = 13; b < 18; b++) begin
      pulse(18'h0_0001 << b);
    end
    check("endpoint output", endpointRequests, 8'h9f);
    rdChk("endpoint flags", ENDPOINT_REQUESTS_INDEX, 8'h9f);
    rdChk("endpoint read clear", ENDPOINT_REQUESTS_INDEX, 8'h80);
    wr(ENDPOINT_REQUESTS_INDEX, 8'h80);
    rdChk("write one ignored", ENDPOINT_REQUESTS_INDEX, 8'h80);
    wr(ENDPOINT_REQUESTS_INDEX, 8'h00);
    rdChk("write zero clears", ENDPOINT_REQUESTS_INDEX, 8'h00);
    // A write without the low byte lane selected must leave the register alone.
    wbXfer(1'b1, EDGE_POLARITY_INDEX, 8'h00, 4'he, rdTmp);
    rdChk("lane ignored", EDGE_POLARITY_INDEX, 8'h0f);
    wr(8'h10, 8'hff);
    rdChk("unmapped", 8'h10, 8'h00);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clock);
    failCount++;
    conclude();
  end
endmodule : interrupt_request_flags_bench
